// File: rtl/tle_ctrl.sv
/*
  Lock elision and explicit transaction control with an APB register slave.
  Assumes the cache keeps speculative line data and discards or publishes it on the
  abort and commit strobes, and that snoops come from logic on the same clock.
*/
// How it works
// - Elided acquire reads lock, enters transaction.
// - Elided acquire: no write-set, no write.
// - Others keep seeing the lock free.
// - Own lock read returns acquired value.
// - Restoring release suppresses write, skips write-set.
// - Elided release then attempts commit.
// - Conflicts are watched and cause aborts.
// - Failed hinted region reruns without elision.
// - Hints ignored when elision is disabled.
// - Begin computes fallback from relative offset.
// - Abort resumes at fallback, writes accumulator.
// - Explicit abort loads immediate into accumulator.
// - Elision feature flag at bit 4.
// - Transaction feature flag at bit 11.
// - Begin, end, abort fault without support.
// - Status query faults only if neither supported.
// - Status query reports transactional execution.
// - Abort discards every update in region.
// - Sets tracked per cache line.
// - Explicit abort: bit 0, immediate on top.
`timescale 1ns/10ps
module tle_ctrl
  import tle_pkg::*;
#(
  parameter int SET_DEPTH = SET_DEPTH_DEF,
  parameter logic [NEST_W-1:0] NEST_MAX = 4'hF
)(
  input wire logic REF_CLK,
  input wire logic RESET_N,
  input wire tle_op_s OP_REQ,
  input wire tle_snp_s SNOOP,
  output tle_rsp_s RSP,
  output tle_wr_s EXT_WR,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [APB_AW-1:0] PADDR,
  input wire logic [DATA_W-1:0] PWDATA,
  output logic [DATA_W-1:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR
);
  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  tle_state_e state_r, state_nxt;
  logic [NEST_W-1:0] nest_r, nest_nxt;
  logic [ADDR_W-1:0] lock_addr_r, acq_pc_r, fallback_r;
  logic [DATA_W-1:0] lock_old_r, lock_new_r, acc_r;
  logic no_elide_r;
  logic [1:0] ctrl_r;
  logic [SET_DEPTH-1:0] rs_v_r, ws_v_r;
  logic [LINE_W-1:0] rs_line_r [SET_DEPTH];
  logic [LINE_W-1:0] ws_line_r [SET_DEPTH];
  tle_rsp_s rsp_nxt;
  tle_wr_s ext_nxt;

  function automatic logic [SET_DEPTH-1:0] lowest_free(input logic [SET_DEPTH-1:0] v);
    return ~v & (v + SET_DEPTH'(1));
  endfunction : lowest_free

  // ---------------------------------------------------------------------------
  // Set lookup
  // ---------------------------------------------------------------------------
  wire [LINE_W-1:0] op_line = OP_REQ.addr[ADDR_W-1:LINE_LSB];
  wire [LINE_W-1:0] snp_line = SNOOP.addr[ADDR_W-1:LINE_LSB];
  logic [SET_DEPTH-1:0] rs_op_hit, ws_op_hit, rs_snp_hit, ws_snp_hit;
  for (genvar i = 0; i < SET_DEPTH; i++)
  begin : g_hit
    // Whole-line compares: neighbours in one line count as the same location.
    assign rs_op_hit[i] = rs_v_r[i] && rs_line_r[i] == op_line;
    assign ws_op_hit[i] = ws_v_r[i] && ws_line_r[i] == op_line;
    assign rs_snp_hit[i] = rs_v_r[i] && rs_line_r[i] == snp_line;
    assign ws_snp_hit[i] = ws_v_r[i] && ws_line_r[i] == snp_line;
  end

  // ---------------------------------------------------------------------------
  // Operation decode
  // ---------------------------------------------------------------------------
  wire hle_en = ctrl_r[CTRL_HLE_BIT];
  wire rtm_en = ctrl_r[CTRL_RTM_BIT];
  wire is_idle = state_r == ST_IDLE;
  wire is_hle = state_r == ST_HLE;
  wire is_rtm = state_r == ST_RTM;
  tle_op_e k;
  assign k = OP_REQ.kind;
  // A snoop conflict wins over the operation of the same cycle; the pipeline replays it.
  wire conflict = SNOOP.valid && !is_idle && (|ws_snp_hit || (SNOOP.write && |rs_snp_hit));
  wire go = OP_REQ.valid && !conflict;
  wire lock_hit = OP_REQ.addr == lock_addr_r;
  wire acq_elide = go && k == OP_ACQ && hle_en && is_idle && !no_elide_r;
  wire rel_match = go && k == OP_REL && is_hle && lock_hit && OP_REQ.wdata == lock_old_r;
  wire lock_bad = go && is_hle && lock_hit &&
                  (k == OP_STORE || (k == OP_REL && OP_REQ.wdata != lock_old_r));
  wire rtm_op = k == OP_BEGIN || k == OP_END || k == OP_ABORT;
  wire ud_rtm = go && rtm_op && !rtm_en;
  wire ud_q = go && k == OP_QUERY && !hle_en && !rtm_en;
  wire beg = go && k == OP_BEGIN && rtm_en;
  wire beg_new = beg && is_idle;
  wire nest_ovf = beg && is_rtm && nest_r == NEST_MAX;
  wire beg_nest = beg && is_rtm && !nest_ovf;
  wire beg_hle = beg && is_hle;
  wire endo = go && k == OP_END && rtm_en && is_rtm;
  wire end_commit = endo && nest_r == NEST_W'(1);
  wire txn_abort_op = go && k == OP_ABORT && rtm_en && is_rtm;
  wire load_in = go && k == OP_LOAD && !is_idle;
  wire self_rd = load_in && is_hle && lock_hit;
  // Non-lock stores inside a region go to the write-set; the cache holds the data back.
  wire wr_in = go && !is_idle && !lock_bad &&
               (k == OP_STORE || k == OP_ACQ || (k == OP_REL && !(is_hle && lock_hit)));
  wire rs_req = acq_elide || (load_in && !self_rd);
  wire ws_req = wr_in;
  wire rs_need = rs_req && !(|rs_op_hit);
  wire ws_need = ws_req && !(|ws_op_hit);
  wire rs_ovf = rs_need && &rs_v_r;
  wire ws_ovf = ws_need && &ws_v_r;
  wire [SET_DEPTH-1:0] rs_slot = lowest_free(rs_v_r);
  wire [SET_DEPTH-1:0] ws_slot = lowest_free(ws_v_r);
  wire do_abort = conflict || lock_bad || nest_ovf || beg_hle || txn_abort_op || rs_ovf || ws_ovf;
  wire do_commit = (rel_match || end_commit) && !do_abort;
  wire clr_sets = do_abort || do_commit;

  // ---------------------------------------------------------------------------
  // Abort status and next state
  // ---------------------------------------------------------------------------
  logic [AB_CAUSE_W-1:0] cause;
  assign cause[AB_EXPLICIT] = txn_abort_op;
  assign cause[AB_RETRY] = conflict;
  assign cause[AB_CONFLICT] = conflict;
  assign cause[AB_OVERFLOW] = rs_ovf || ws_ovf;
  assign cause[4] = 1'b0;
  assign cause[AB_NESTED] = is_rtm && (nest_r > NEST_W'(1) || nest_ovf);
  wire [7:0] ab_imm = txn_abort_op ? OP_REQ.imm : 8'h00;
  wire [DATA_W-1:0] ab_word = {ab_imm, {AB_RSVD_W{1'b0}}, cause};

  assign state_nxt = clr_sets ? ST_IDLE : acq_elide ? ST_HLE : beg_new ? ST_RTM : state_r;
  assign nest_nxt = clr_sets ? '0 : beg_new ? NEST_W'(1) : beg_nest ? nest_r + NEST_W'(1)
                  : endo ? nest_r - NEST_W'(1) : nest_r;

  assign rsp_nxt = '{
    commit: do_commit,
    abort: do_abort,
    restart_pc: is_rtm ? fallback_r : acq_pc_r,
    acc_we: do_abort && is_rtm,
    acc_data: ab_word,
    rd_hit: self_rd,
    rd_data: lock_new_r,
    query_valid: go && k == OP_QUERY && !ud_q,
    query_active: !is_idle,
    fault_ud: ud_rtm || ud_q
  };
  // Only a non-elided lock write leaves the core; an elided one never does.
  assign ext_nxt = '{
    valid: go && is_idle && ((k == OP_ACQ && !acq_elide) || k == OP_REL),
    addr: OP_REQ.addr,
    data: OP_REQ.wdata
  };

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      state_r <= ST_IDLE;
      nest_r <= '0;
      no_elide_r <= 1'b0;
      acc_r <= '0;
      RSP <= '0;
      EXT_WR <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      nest_r <= nest_nxt;
      RSP <= rsp_nxt;
      EXT_WR <= ext_nxt;
      // After a failed hinted region the replay takes the lock for real.
      if (do_abort && is_hle)
        no_elide_r <= 1'b1;
      else if (go && is_idle && k == OP_REL)
        no_elide_r <= 1'b0;
      if (do_abort && is_rtm)
        acc_r <= ab_word;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      lock_addr_r <= '0;
      lock_old_r <= '0;
      lock_new_r <= '0;
      acq_pc_r <= '0;
      fallback_r <= '0;
    end
    else
    begin
      if (acq_elide)
      begin
        lock_addr_r <= OP_REQ.addr;
        lock_old_r <= OP_REQ.old;
        lock_new_r <= OP_REQ.wdata;
        acq_pc_r <= OP_REQ.next_pc;
      end
      if (beg_new)
        fallback_r <= OP_REQ.next_pc + OP_REQ.rel;
    end
  end

  always_ff @(posedge REF_CLK)
  begin
    for (int i = 0; i < SET_DEPTH; i++)
    begin
      if (!RESET_N || clr_sets)
      begin
        rs_v_r[i] <= 1'b0;
        ws_v_r[i] <= 1'b0;
      end
      else
      begin
        if (rs_need && rs_slot[i])
        begin
          rs_v_r[i] <= 1'b1;
          rs_line_r[i] <= op_line;
        end
        if (ws_need && ws_slot[i])
        begin
          ws_v_r[i] <= 1'b1;
          ws_line_r[i] <= op_line;
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // APB slave: one wait state, then a registered answer.
  // ---------------------------------------------------------------------------
  wire apb_acc = PSEL && PENABLE && !PREADY;
  wire apb_done = PSEL && PENABLE && PREADY;
  wire [DATA_W-1:0] feat_w = (DATA_W'(hle_en) << FEAT_HLE_BIT) | (DATA_W'(rtm_en) << FEAT_RTM_BIT);
  wire [DATA_W-1:0] stat_w = {{(DATA_W-9){1'b0}}, no_elide_r, nest_r, 1'b0, state_r};
  wire mapped = PADDR == OFF_CTRL || PADDR == OFF_STAT || PADDR == OFF_ACC || PADDR == OFF_FEAT;
  wire [DATA_W-1:0] rd_mux = PADDR == OFF_CTRL ? {{(DATA_W-2){1'b0}}, ctrl_r}
                           : PADDR == OFF_STAT ? stat_w
                           : PADDR == OFF_ACC ? acc_r
                           : PADDR == OFF_FEAT ? feat_w : '0;

  always_ff @(posedge REF_CLK)
  begin
    if (!RESET_N)
    begin
      ctrl_r <= CTRL_RST;
      PREADY <= 1'b0;
      PRDATA <= '0;
      PSLVERR <= 1'b0;
    end
    else
    begin
      PREADY <= apb_acc;
      PSLVERR <= apb_acc && !mapped;
      PRDATA <= (apb_acc && !PWRITE) ? rd_mux : '0;
      // A write lands only at the edge that completes the transfer.
      if (apb_done && PWRITE && PADDR == OFF_CTRL)
        ctrl_r <= PWDATA[1:0];
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_elided_acq;
    acq_elide ##1 state_r == ST_HLE;
  endsequence
  sequence s_hle_abort;
    do_abort && is_hle;
  endsequence

  a_elide_enter: assert property (acq_elide |=> state_r == ST_HLE && rs_v_r[0] && !ws_v_r[0])
    else $error("elided acquire did not enter region");
  a_elide_silent: assert property (s_elided_acq |-> !EXT_WR.valid)
    else $error("elided acquire leaked a lock write");
  a_self_read: assert property (self_rd |=> RSP.rd_hit && RSP.rd_data == $past(lock_new_r))
    else $error("own lock read did not see acquired value");
  a_release_commit: assert property (rel_match && !conflict |=> RSP.commit && !EXT_WR.valid)
    else $error("restoring release did not commit silently");
  a_conflict_abort: assert property (conflict |=> RSP.abort && state_r == ST_IDLE && rs_v_r == '0 && ws_v_r == '0)
    else $error("conflict did not abort");
  a_hle_replay: assert property (s_hle_abort |=> no_elide_r && RSP.restart_pc == $past(acq_pc_r))
    else $error("hinted region not replayed without elision");
  a_rtm_fallback: assert property (do_abort && is_rtm |=> RSP.restart_pc == $past(fallback_r) && RSP.acc_we)
    else $error("explicit abort missed fallback or status");
  a_abort_imm: assert property (txn_abort_op |=> RSP.acc_data[31:24] == $past(OP_REQ.imm) && RSP.acc_data[0])
    else $error("explicit abort status wrong");
  a_ud_rtm: assert property (ud_rtm |=> RSP.fault_ud && !RSP.commit && $stable(state_r))
    else $error("missing fault without transaction support");
  a_query_state: assert property (go && k == OP_QUERY && !ud_q |=> RSP.query_valid && RSP.query_active == !$past(is_idle))
    else $error("status query answer wrong");
  a_feat_read: assert property (apb_acc && !PWRITE && PADDR == OFF_FEAT |=> PRDATA[FEAT_RTM_BIT] == $past(rtm_en))
    else $error("feature flag read wrong");
endmodule : tle_ctrl

// File: rtl/tle_pkg.sv
/*
  Shared constants and carriers for the lock elision and transaction control block.
  Assumes a 32-bit APB register bus and a pipeline that hands over one operation per cycle.
*/
package tle_pkg;
  localparam int ADDR_W = 32;
  localparam int DATA_W = 32;
  localparam int LINE_LSB = 6;
  localparam int LINE_W = ADDR_W - LINE_LSB;
  localparam int SET_DEPTH_DEF = 8;
  localparam int NEST_W = 4;
  localparam int APB_AW = 12;
  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam logic [APB_AW-1:0] OFF_CTRL = 12'h000;
  localparam logic [APB_AW-1:0] OFF_STAT = 12'h004;
  localparam logic [APB_AW-1:0] OFF_ACC = 12'h008;
  localparam logic [APB_AW-1:0] OFF_FEAT = 12'h00C;
  localparam logic [1:0] CTRL_RST = 2'h3;
  localparam int CTRL_HLE_BIT = 0;
  localparam int CTRL_RTM_BIT = 1;
  localparam int FEAT_HLE_BIT = 4;
  localparam int FEAT_RTM_BIT = 11;
  // ---------------------------------------------------------------------------
  // Abort status layout
  // ---------------------------------------------------------------------------
  localparam int AB_EXPLICIT = 0;
  localparam int AB_RETRY = 1;
  localparam int AB_CONFLICT = 2;
  localparam int AB_OVERFLOW = 3;
  localparam int AB_NESTED = 5;
  localparam int AB_CAUSE_W = 6;
  localparam int AB_RSVD_W = 18;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_LOAD = 4'h1, OP_STORE = 4'h2, OP_ACQ = 4'h3, OP_REL = 4'h4,
    OP_BEGIN = 4'h5, OP_END = 4'h6, OP_ABORT = 4'h7, OP_QUERY = 4'h8
  } tle_op_e;
  typedef enum logic [2:0] {ST_IDLE = 3'b001, ST_HLE = 3'b010, ST_RTM = 3'b100} tle_state_e;

  typedef struct packed {
    logic valid;
    tle_op_e kind;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic [DATA_W-1:0] old;
    logic [ADDR_W-1:0] next_pc;
    logic [ADDR_W-1:0] rel;
    logic [7:0] imm;
  } tle_op_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic [ADDR_W-1:0] addr;
  } tle_snp_s;
  typedef struct packed {
    logic commit;
    logic abort;
    logic [ADDR_W-1:0] restart_pc;
    logic acc_we;
    logic [DATA_W-1:0] acc_data;
    logic rd_hit;
    logic [DATA_W-1:0] rd_data;
    logic query_valid;
    logic query_active;
    logic fault_ud;
  } tle_rsp_s;
  typedef struct packed {
    logic valid;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } tle_wr_s;
endpackage : tle_pkg

// File: verif/tle_peer.sv
/*
  Model of another logical processor sharing the coherent memory with the block.
  Assumes one clock shared with the block and a single lock word that the bench names.
*/
`timescale 1ns/10ps
module tle_peer
  import tle_pkg::*;
#(
  parameter logic [ADDR_W-1:0] LOCK_ADDR = 32'h0000_1000
)(
  input wire logic clk,
  input wire logic rst_n,
  input wire tle_wr_s ext_wr,
  output tle_snp_s snoop,
  output logic [DATA_W-1:0] lock_val
);
  // The peer only learns the lock value from real external writes, so a lock
  // that the block elides must keep reading as its old value here.
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lock_val <= '0;
    else if (ext_wr.valid && ext_wr.addr == LOCK_ADDR)
      lock_val <= ext_wr.data;
  end

  initial snoop = '0;

  // One-cycle access; the address is inverted afterwards so no stale line lingers.
  task automatic send(input logic w, input logic [ADDR_W-1:0] a);
    @(posedge clk);
    snoop <= '{valid: 1'b1, write: w, addr: a};
    @(posedge clk);
    snoop <= '{valid: 1'b0, write: 1'b0, addr: ~a};
  endtask : send
endmodule : tle_peer

// File: verif/tle_ctrl_bench.sv
/*
  Self-checking bench for the elision and transaction control block.
  Assumes the one-cycle operation response and the register map of the block.
*/
`timescale 1ns/10ps
module tle_ctrl_bench
  import tle_pkg::*;
;
  localparam logic [31:0] LOCK_A = 32'h0000_1000;
  logic clk;
  logic rst_n;
  tle_op_s op;
  tle_snp_s snp_w;
  tle_rsp_s rsp;
  tle_wr_s wr;
  logic psel, penable, pwrite, pready, pslverr, err_q;
  logic [APB_AW-1:0] paddr;
  logic [31:0] pwdata, prdata, lock_val, rd_q;
  tle_rsp_s rsp_q;
  tle_wr_s wr_q;
  int n_fail;
  int checks;
  tle_op_e ul[4] = '{OP_BEGIN, OP_END, OP_ABORT, OP_QUERY};

  tle_ctrl tle_ctrl_inst (.REF_CLK(clk), .RESET_N(rst_n), .OP_REQ(op), .SNOOP(snp_w), .RSP(rsp),
    .EXT_WR(wr), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr));
  tle_peer #(.LOCK_ADDR(LOCK_A)) tle_peer_inst (.clk(clk), .rst_n(rst_n), .ext_wr(wr), .snoop(snp_w),
    .lock_val(lock_val));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------------------
  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %h seen %h", nm, e, g);
      n_fail++;
    end
  endtask : cmp_word

  task automatic cmp_bit(input string nm, input logic e, input logic g);
    checks++;
    if (g !== e)
    begin
      $display("unexpected %s expected %b seen %b", nm, e, g);
      n_fail++;
    end
  endtask : cmp_bit

  task automatic do_op(input tle_op_e k, input logic [31:0] a = 32'h0, input logic [31:0] d = 32'h0,
    input logic [31:0] npc = 32'h0, input logic [31:0] rel = 32'h0, input logic [7:0] imm = 8'h00);
    @(posedge clk);
    op <= '{valid: 1'b1, kind: k, addr: a, wdata: d, old: 32'h0, next_pc: npc, rel: rel, imm: imm};
    @(posedge clk);
    op <= '0;
    #1;
    rsp_q = rsp;
    wr_q = wr;
  endtask : do_op

  task automatic snp(input logic w, input logic [31:0] a);
    tle_peer_inst.send(w, a);
    #1;
    rsp_q = rsp;
  endtask : snp

  // Pready, read data and error are taken at the rising edge that completes the access.
  task automatic apb(input logic w, input logic [APB_AW-1:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do
      @(posedge clk);
    while (pready !== 1'b1);
    rd_q = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rd_chk(input logic [APB_AW-1:0] a, input logic [31:0] e, input string nm);
    apb(1'b0, a, 32'h0);
    cmp_word(nm, e, rd_q);
  endtask : rd_chk

  task automatic print_verdict();
    if (n_fail == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : print_verdict

  initial
  begin
    #100000;
    n_fail++;
    print_verdict();
  end

  // ---------------------------------------------------------------------------
  // Tests
  // ---------------------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    op = '0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    n_fail = 0;
    checks = 0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rd_chk(OFF_CTRL, 32'h0000_0003, "ctrl");
    rd_chk(OFF_FEAT, 32'h0000_0810, "feat");
    rd_chk(OFF_STAT, 32'h0000_0001, "stat");
    apb(1'b0, 12'h010, 32'h0);
    cmp_bit("pslverr", 1'b1, err_q);
    do_op(OP_ACQ, LOCK_A, 32'h0000_0001, 32'h0000_0200);
    cmp_bit("acq ext_wr", 1'b0, wr_q.valid);
    cmp_word("peer lock", 32'h0, lock_val);
    rd_chk(OFF_STAT, 32'h0000_0002, "stat hle");
    do_op(OP_LOAD, LOCK_A);
    cmp_bit("rd_hit", 1'b1, rsp_q.rd_hit);
    cmp_word("rd_data", 32'h0000_0001, rsp_q.rd_data);
    do_op(OP_QUERY);
    cmp_bit("active", 1'b1, rsp_q.query_active & rsp_q.query_valid);
    do_op(OP_REL, LOCK_A);
    cmp_bit("commit", 1'b1, rsp_q.commit);
    cmp_bit("rel ext_wr", 1'b0, wr_q.valid);
    do_op(OP_ACQ, LOCK_A, 32'h0000_0001, 32'h0000_0200);
    snp(1'b1, LOCK_A + 32'h0000_0004);
    cmp_bit("hle abort", 1'b1, rsp_q.abort);
    cmp_word("hle restart", 32'h0000_0200, rsp_q.restart_pc);
    do_op(OP_ACQ, LOCK_A, 32'h0000_0001, 32'h0000_0200);
    cmp_word("replay wr", 32'h0000_0001, wr_q.valid ? wr_q.data : 32'hFFFF_FFFF);
    cmp_word("replay addr", LOCK_A, wr_q.addr);
    do_op(OP_REL, LOCK_A);
    cmp_bit("replay rel", 1'b1, wr_q.valid);
    do_op(OP_BEGIN, 32'h0, 32'h0, 32'h0000_0100, 32'h0000_0040);
    do_op(OP_STORE, 32'h0000_2000, 32'h0000_0007);
    do_op(OP_ABORT, 32'h0, 32'h0, 32'h0, 32'h0, 8'h5A);
    cmp_bit("txn_abort_op", 1'b1, rsp_q.abort & rsp_q.acc_we);
    cmp_word("fallback", 32'h0000_0140, rsp_q.restart_pc);
    cmp_word("acc", 32'h5A00_0001, rsp_q.acc_data);
    rd_chk(OFF_ACC, 32'h5A00_0001, "acc reg");
    do_op(OP_BEGIN, 32'h0, 32'h0, 32'h0000_0300, 32'h0000_0010);
    do_op(OP_STORE, 32'h0000_2000, 32'h0000_0007);
    snp(1'b0, 32'h0000_2020);
    cmp_bit("rtm abort", 1'b1, rsp_q.abort);
    cmp_word("cause", 32'h0000_0006, rsp_q.acc_data & 32'h0000_0007);
    cmp_word("fallback2", 32'h0000_0310, rsp_q.restart_pc);
    do_op(OP_BEGIN, 32'h0, 32'h0, 32'h0000_0300, 32'h0000_0010);
    do_op(OP_STORE, 32'h0000_2000, 32'h0000_0007);
    do_op(OP_END);
    cmp_bit("rtm commit", 1'b1, rsp_q.commit);
    apb(1'b1, OFF_CTRL, 32'h0000_0002);
    rd_chk(OFF_FEAT, 32'h0000_0800, "feat rtm");
    do_op(OP_ACQ, LOCK_A, 32'h0000_0001);
    cmp_bit("plain acq", 1'b1, wr_q.valid);
    rd_chk(OFF_STAT, 32'h0000_0001, "stat plain");
    do_op(OP_REL, LOCK_A);
    apb(1'b1, OFF_CTRL, 32'h0000_0000);
    rd_chk(OFF_FEAT, 32'h0000_0000, "feat none");
    for (int i = 0; i < 4; i++)
    begin
      do_op(ul[i]);
      cmp_bit("fault", 1'b1, rsp_q.fault_ud);
    end
    apb(1'b1, OFF_CTRL, 32'h0000_0001);
    do_op(OP_QUERY);
    cmp_bit("query ok", 1'b0, rsp_q.fault_ud);
    do_op(OP_BEGIN);
    cmp_bit("begin fault", 1'b1, rsp_q.fault_ud);
    apb(1'b1, OFF_FEAT, 32'h0000_0000);
    rd_chk(OFF_FEAT, 32'h0000_0010, "feat ro");
    print_verdict();
  end
endmodule : tle_ctrl_bench
